// [logic/itc_pkg.sv]
// package of register offsets, control field layout and event codes
// assumes: one context per instance, 32-bit plain register port
package itc_pkg;
   // ******************************************************************
   // register map (word byte addresses)
   // ******************************************************************
   localparam logic [7:0] ADDR_PROGRAM_POINTER = 8'h00;
   localparam logic [7:0] ADDR_CTRL_SET        = 8'h04;
   localparam logic [7:0] ADDR_CTRL_CLEAR      = 8'h08;
   localparam logic [7:0] ADDR_CYCLE_TIME      = 8'h0C;

   // ******************************************************************
   // control field positions
   // ******************************************************************
   localparam int CTL_START_ON_CYCLE_BIT = 31;
   localparam int CTL_START_VALUE_LSB    = 16;
   localparam int CTL_START_VALUE_W      = 15;
   localparam int CTL_RUN_BIT            = 15;
   localparam int CTL_WAKE_BIT           = 12;
   localparam int CTL_DEAD_BIT           = 11;
   localparam int CTL_ACTIVE_BIT         = 10;
   localparam int CTL_EVENT_LSB          = 0;
   localparam int CTL_EVENT_W            = 5;

   // reset values of control state
   localparam logic       RST_RUN    = 1'b0;
   localparam logic       RST_ACTIVE = 1'b0;
   localparam logic       RST_DEAD   = 1'b0;
   localparam logic [4:0] RST_EVENT  = 5'h00;

   // ******************************************************************
   // block-count code
   // ******************************************************************
   localparam int         BLOCK_CODE_W     = 4;
   localparam logic [3:0] BLOCK_CODE_LAST  = 4'h0;
   localparam logic [3:0] BLOCK_CODE_MAX   = 4'h8;

   // cycle time layout: seconds above the 13-bit cycle number
   localparam int CYCLE_NUMBER_W   = 13;
   localparam int CYCLE_NUMBER_LSB = 12;
   localparam int SECONDS_LSB      = 25;

   // completion event codes (arbitrary values)
   localparam logic [4:0] EVT_COMPLETE  = 5'h11;
   localparam logic [4:0] EVT_UNDERRUN  = 5'h04;
   localparam logic [4:0] EVT_DESC_READ = 5'h05;
   localparam logic [4:0] EVT_DATA_READ = 5'h06;
   localparam logic [4:0] EVT_TCODE_ERR = 5'h0B;
   localparam logic [4:0] EVT_UNKNOWN   = 5'h0E;

   // decoded block-count code
   typedef struct packed {
      logic       last;
      logic       valid;
      logic [3:0] count;
   } block_info_t;

   // completion report from the descriptor engine
   typedef struct packed {
      logic       valid;
      logic [4:0] code;
   } completion_t;
endpackage

// [logic/start_matcher.sv]
// start-on-cycle comparator on the cycle start stream
// assumes: cycle start strobe and time come from same clock domain
`timescale 1ns/1ps
module start_matcher
   import itc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        cycle_start_in,
   input  wire logic [31:0] bus_cycle_time_in,
   input  wire logic [14:0] start_cycle_value_in,
   output logic             match_out
);
   // ******************************************************************
   // compare two seconds bits plus cycle number, registered
   // ******************************************************************
   logic [14:0] now_cycle;
   assign now_cycle = {bus_cycle_time_in[SECONDS_LSB +: 2],
                       bus_cycle_time_in[CYCLE_NUMBER_LSB +: CYCLE_NUMBER_W]};

   // one-cycle pulse per matching cycle start
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         match_out <= 1'b0;
      end else begin
         match_out <= cycle_start_in && (now_cycle == start_cycle_value_in);
      end
   end
endmodule

// [logic/iso_transmit_context_control.sv]
// control and status of one isochronous transmit context
// assumes: descriptor engine on same clock reports completions and
// consumes the start pulse; software on a plain strobe register port
`timescale 1ns/1ps

module iso_transmit_context_control
   import itc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   // cycle timing from the link
   input  wire logic        cycle_start_in,
   input  wire logic [31:0] bus_cycle_time_in,
   // descriptor engine side
   input  wire logic        completion_valid_in,
   input  wire logic [4:0]  completion_code_in,
   input  wire logic        engine_dead_in,
   input  wire logic        wake_consumed_in,
   output logic             start_pulse_out,
   output logic             prefetch_ok_out,
   output logic [27:0]      descriptor_base_address_out,
   output logic [3:0]       block_count_out,
   output logic             program_end_out,
   output logic             code_reserved_out,
   output logic             run_out,
   output logic             active_out
);
   // ******************************************************************
   // block-count decoding
   // ******************************************************************
   function automatic block_info_t decode_block(input logic [3:0] code);
      block_info_t info;
      info.last  = (code == BLOCK_CODE_LAST);
      info.valid = (code <= BLOCK_CODE_MAX);
      info.count = info.valid ? code : 4'h0;
      return info;
   endfunction

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_WAIT    = 3'b010,
      ST_ACTIVE  = 3'b100
   } ctx_state_t;

   // ******************************************************************
   // registers
   // ******************************************************************
   logic [31:0]  program_pointer;
   logic         start_on_cycle_enable;
   logic [14:0]  start_cycle_value;
   logic         run;
   logic         wake;
   logic         dead;
   logic         active;
   logic [4:0]   event_code;
   ctx_state_t   state;
   ctx_state_t   next_state;
   logic         match;
   block_info_t  block_info;
   completion_t  completion;

   logic wr_ptr;
   logic wr_set;
   logic wr_clr;
   assign wr_ptr = wr_in && (addr_in == ADDR_PROGRAM_POINTER);
   assign wr_set = wr_in && (addr_in == ADDR_CTRL_SET);
   assign wr_clr = wr_in && (addr_in == ADDR_CTRL_CLEAR);

   assign completion.valid = completion_valid_in;
   assign completion.code  = completion_code_in;

   start_matcher u_match (
      .clk_in               (clk_in),
      .rst_in               (rst_in),
      .cycle_start_in       (cycle_start_in),
      .bus_cycle_time_in    (bus_cycle_time_in),
      .start_cycle_value_in (start_cycle_value),
      .match_out            (match)
   );

   // program pointer, plain read/write word
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         program_pointer <= 32'h00000000;
      end else if (wr_ptr) begin
         program_pointer <= wdata_in;
      end
   end

   // pointer split: address above, block code in the low nibble
   assign block_info = decode_block(program_pointer[BLOCK_CODE_W-1:0]);
   assign descriptor_base_address_out = program_pointer[31:4];
   assign block_count_out   = block_info.count;
   assign program_end_out   = block_info.last;
   assign code_reserved_out = ~block_info.valid;

   // ******************************************************************
   // software-owned control bits
   // ******************************************************************
   // run changes only by software set and clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         run <= RST_RUN;
      end else if (wr_set && wdata_in[CTL_RUN_BIT]) begin
         run <= 1'b1;
      end else if (wr_clr && wdata_in[CTL_RUN_BIT]) begin
         run <= 1'b0;
      end
   end

   // start value field; reset value arbitrary since undefined
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         start_cycle_value <= 15'h0000;
      end else if (wr_set) begin
         start_cycle_value <= start_cycle_value |
            wdata_in[CTL_START_VALUE_LSB +: CTL_START_VALUE_W];
      end else if (wr_clr) begin
         start_cycle_value <= start_cycle_value &
            ~wdata_in[CTL_START_VALUE_LSB +: CTL_START_VALUE_W];
      end
   end

   // enable: software sets/clears, hardware clears when activating
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         start_on_cycle_enable <= 1'b0;
      end else if (wr_set && wdata_in[CTL_START_ON_CYCLE_BIT]) begin
         start_on_cycle_enable <= 1'b1;
      end else if (wr_clr && wdata_in[CTL_START_ON_CYCLE_BIT]) begin
         start_on_cycle_enable <= 1'b0;
      end else if (state == ST_WAIT && match) begin
         start_on_cycle_enable <= 1'b0;
      end
   end

   // wake: set wins over engine consumption; clear port has no effect
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wake <= 1'b0;
      end else if (wr_set && wdata_in[CTL_WAKE_BIT]) begin
         wake <= 1'b1;
      end else if (wake_consumed_in) begin
         wake <= 1'b0;
      end
   end

   // ******************************************************************
   // activation state machine
   // ******************************************************************
   // decided on register values, so a pending write is seen next cycle
   always_comb begin
      next_state = state;
      case (state)
         // a dead context in ST_IDLE stays stopped until software drops run; ST_WAIT ignores dead
         ST_IDLE: begin
            if (run && !dead && !start_on_cycle_enable) begin
               next_state = ST_ACTIVE;
            end else if (run && !dead) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!run) begin
               next_state = ST_IDLE;
            end else if (match || !start_on_cycle_enable) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!run || dead) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // active mirrors the state; hardware only
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         active <= RST_ACTIVE;
      end else begin
         active <= (next_state == ST_ACTIVE);
      end
   end

   // dead: engine reports fatal error, cleared when run drops
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dead <= RST_DEAD;
      end else if (engine_dead_in && run) begin
         dead <= 1'b1;
      end else if (!run) begin
         dead <= 1'b0;
      end
   end

   // completion status of each final output command
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         event_code <= RST_EVENT;
      end else if (completion.valid) begin
         case (completion.code)
            EVT_COMPLETE, EVT_UNDERRUN, EVT_DESC_READ,
            EVT_DATA_READ, EVT_TCODE_ERR: event_code <= completion.code;
            default:                      event_code <= EVT_UNKNOWN;
         endcase
      end
   end

   // one-cycle start pulse on entering active
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         start_pulse_out <= 1'b0;
      end else begin
         start_pulse_out <= (next_state == ST_ACTIVE) && (state != ST_ACTIVE);
      end
   end

   // engine may fetch the first block while waiting for the match
   assign prefetch_ok_out = (state == ST_WAIT) || active;
   assign run_out         = run;
   assign active_out      = active;

   // ******************************************************************
   // register read
   // ******************************************************************
   // both control ports return one image; reserved bits read zero
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= 32'h00000000;
      end else if (rd_in) begin
         rdata_out <= 32'h00000000;
         case (addr_in)
            ADDR_PROGRAM_POINTER: rdata_out <= program_pointer;
            ADDR_CTRL_SET, ADDR_CTRL_CLEAR: begin
               rdata_out[CTL_START_ON_CYCLE_BIT] <= start_on_cycle_enable;
               rdata_out[CTL_START_VALUE_LSB +: CTL_START_VALUE_W] <= start_cycle_value;
               rdata_out[CTL_RUN_BIT]    <= run;
               rdata_out[CTL_WAKE_BIT]   <= wake;
               rdata_out[CTL_DEAD_BIT]   <= dead;
               rdata_out[CTL_ACTIVE_BIT] <= active;
               rdata_out[CTL_EVENT_LSB +: CTL_EVENT_W] <= event_code;
            end
            ADDR_CYCLE_TIME: rdata_out <= bus_cycle_time_in;
            default: rdata_out <= 32'h00000000;
         endcase
      end else begin
         rdata_out <= 32'h00000000;
      end
   end
endmodule

// [testbench/itc_asserts.sv]
// checker of register port timing, run and active behaviour, decode
// assumes: bound to iso_transmit_context_control, one clock domain
`timescale 1ns/1ps
module itc_asserts
   import itc_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic [7:0]  addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic        start_pulse_out,
   input wire logic        prefetch_ok_out,
   input wire logic [27:0] descriptor_base_address_out,
   input wire logic [3:0]  block_count_out,
   input wire logic        program_end_out,
   input wire logic        code_reserved_out,
   input wire logic        run_out,
   input wire logic        active_out
);
   // *****************
   // properties
   // *****************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // read data stand only in the cycle after a read
   property p_rd_idle; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_run_set; wr_in && addr_in == ADDR_CTRL_SET && wdata_in[CTL_RUN_BIT] |=> run_out;
   endproperty
   a_run_set: assert property (p_run_set) else $error("run not set");
   property p_run_clr; wr_in && addr_in == ADDR_CTRL_CLEAR && wdata_in[CTL_RUN_BIT] |=> !run_out;
   endproperty
   a_run_clr: assert property (p_run_clr) else $error("run not cleared");
   // run moves only on a software write
   property p_run_keep; !wr_in |=> run_out == $past(run_out); endproperty
   a_run_keep: assert property (p_run_keep) else $error("run changed alone");
   property p_act_run; $rose(active_out) |-> run_out; endproperty
   a_act_run: assert property (p_act_run) else $error("active without run");
   property p_pulse; start_pulse_out == $rose(active_out); endproperty
   a_pulse: assert property (p_pulse) else $error("start pulse misplaced");
   property p_pref; active_out |-> prefetch_ok_out; endproperty
   a_pref: assert property (p_pref) else $error("no prefetch while active");
   property p_dec; ((block_count_out == 4'h0) == (program_end_out | code_reserved_out))
      && (block_count_out <= BLOCK_CODE_MAX); endproperty
   a_dec: assert property (p_dec) else $error("block code decode wrong");
   property p_ptr; wr_in && addr_in == ADDR_PROGRAM_POINTER
      |=> {4'h0, descriptor_base_address_out} == ($past(wdata_in) >> 4); endproperty
   a_ptr: assert property (p_ptr) else $error("descriptor address wrong");
   // main scenarios reached
   c_active: cover property ($rose(active_out));
   c_resv: cover property (code_reserved_out);
   c_read: cover property (rd_in ##1 rdata_out != 32'h0);
endmodule

bind iso_transmit_context_control itc_asserts i_itc_asserts (.clk_in(clk_in), .rst_in(rst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .start_pulse_out(start_pulse_out),
   .prefetch_ok_out(prefetch_ok_out), .descriptor_base_address_out(descriptor_base_address_out),
   .block_count_out(block_count_out), .program_end_out(program_end_out),
   .code_reserved_out(code_reserved_out), .run_out(run_out), .active_out(active_out));

// [testbench/iso_transmit_context_control_tb_top.sv]
// self-checking bench of the transmit context control block
// assumes: itc_pkg compiled first, checker bound from its own file
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module iso_transmit_context_control_tb_top
   import itc_pkg::*;
;
   logic        clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, cycle_start_in = 1'b0;
   logic        completion_valid_in = 1'b0, engine_dead_in = 1'b0, wake_consumed_in = 1'b0;
   logic [7:0]  addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0, bus_cycle_time_in = 32'h0, rdata_out;
   logic [4:0]  completion_code_in = 5'h00;
   logic [27:0] descriptor_base_address_out;
   logic [3:0]  block_count_out;
   logic        start_pulse_out, prefetch_ok_out, program_end_out, code_reserved_out;
   logic        run_out, active_out;
   int          miscompares = 0, checked = 0;
   logic [3:0]  codes[5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hF};
   logic [4:0]  evts[6] = '{EVT_COMPLETE, EVT_UNDERRUN, EVT_DESC_READ, EVT_DATA_READ,
                            EVT_TCODE_ERR, EVT_UNKNOWN};
   // 200 MHz clock
   always #2.5 clk_in = ~clk_in;
   iso_transmit_context_control i_iso_transmit_context_control (.clk_in(clk_in),
      .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .cycle_start_in(cycle_start_in),
      .bus_cycle_time_in(bus_cycle_time_in), .completion_valid_in(completion_valid_in),
      .completion_code_in(completion_code_in), .engine_dead_in(engine_dead_in),
      .wake_consumed_in(wake_consumed_in), .start_pulse_out(start_pulse_out),
      .prefetch_ok_out(prefetch_ok_out),
      .descriptor_base_address_out(descriptor_base_address_out),
      .block_count_out(block_count_out), .program_end_out(program_end_out),
      .code_reserved_out(code_reserved_out), .run_out(run_out), .active_out(active_out));
   // *****************
   // bus tasks
   // *****************
   task automatic do_reset;
      rst_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask
   // reserved control bits are masked out of the compare, though the block reads them as zero
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] m;
      m = (a == ADDR_CTRL_SET || a == ADDR_CTRL_CLEAR) ? 32'hFFFF_9C1F : 32'hFFFF_FFFF;
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1;
      `CHK(rdata_out & m, e)
   endtask
   // one cycle start, then the two cycles a match needs to land
   task automatic cyc(input logic [31:0] t);
      @(posedge clk_in);
      bus_cycle_time_in <= t;
      cycle_start_in    <= 1'b1;
      @(posedge clk_in);
      cycle_start_in    <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // *****************
   // tests
   // *****************
   initial begin
      do_reset;
      rdc(ADDR_CTRL_SET, 32'h0);
      rdc(8'h10, 32'h0);
      foreach (codes[i]) begin
         wr(ADDR_PROGRAM_POINTER, 32'h1234_5670 | codes[i]);
         rdc(ADDR_PROGRAM_POINTER, 32'h1234_5670 | codes[i]);
         `CHK(descriptor_base_address_out, 28'h123_4567)
         `CHK(block_count_out, codes[i] <= 4'h8 ? codes[i] : 4'h0)
         `CHK(program_end_out, codes[i] == 4'h0)
         `CHK(code_reserved_out, codes[i] > 4'h8)
      end
      wr(ADDR_CTRL_SET, 32'h0000_1C1F);
      wr(ADDR_CTRL_CLEAR, 32'h0000_1000);
      rdc(ADDR_CTRL_SET, 32'h0000_1000);
      rdc(ADDR_CTRL_CLEAR, 32'h0000_1000);
      wr(ADDR_CTRL_SET, 32'h0000_8000);
      @(posedge clk_in);
      #1;
      `CHK(active_out, 1'b1)
      rdc(ADDR_CTRL_CLEAR, 32'h0000_9400);
      // dead rides along with the first completion and stops the context
      foreach (evts[i]) begin
         @(posedge clk_in);
         completion_valid_in <= 1'b1;
         completion_code_in  <= evts[i];
         engine_dead_in      <= (i == 0);
         @(posedge clk_in);
         completion_valid_in <= 1'b0;
         engine_dead_in      <= 1'b0;
         rdc(ADDR_CTRL_CLEAR, 32'h0000_9800 | evts[i]);
      end
      // unlisted code reports unknown; engine consumes wake meanwhile
      @(posedge clk_in);
      completion_valid_in <= 1'b1;
      completion_code_in  <= 5'h1F;
      wake_consumed_in    <= 1'b1;
      @(posedge clk_in);
      completion_valid_in <= 1'b0;
      wake_consumed_in    <= 1'b0;
      rdc(ADDR_CTRL_CLEAR, 32'h0000_8800 | EVT_UNKNOWN);
      wr(ADDR_CTRL_CLEAR, 32'h0000_8000);
      @(posedge clk_in);
      #1;
      `CHK(run_out, 1'b0)
      do_reset;
      wr(ADDR_CTRL_SET, 32'hAABC_8000);
      cyc(32'hA4AB_C000);
      `CHK(active_out, 1'b0)
      `CHK(prefetch_ok_out, 1'b1)
      cyc(32'hA2AB_D000);
      `CHK(active_out, 1'b0)
      cyc(32'hA2AB_C000);
      `CHK(active_out, 1'b1)
      rdc(ADDR_CTRL_SET, 32'h2ABC_8400);
      do_reset;
      wr(ADDR_CTRL_SET, 32'hAABC_8000);
      wr(ADDR_CTRL_CLEAR, 32'h8000_0000);
      rdc(ADDR_CTRL_SET, 32'h2ABC_8400);
      end_of_test;
   end
   // watchdog well past the roughly 110 cycles the tests take
   initial begin
      #20us;
      miscompares++;
      end_of_test;
   end
endmodule
